// ===== logic/sap_pkg.sv
/*
  Shared constants, configuration carriers and state encodings for the
  stereo audio serial port.
  Assumes a single 250 MHz system clock with a synchronous active-high reset.
*/
`default_nettype none

package sap_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and sizes
  localparam int SAP_PSC_W = 5;
  localparam int SAP_WORD_W = 16;
  // 32 entries of 16 bits give 64 bytes per direction
  localparam int SAP_FIFO_DEPTH = 32;

  ////////////////////////////////////////////////////////////////////////////
  // word lengths and bit-slot counter limits
  localparam logic [4:0] SAP_WL8 = 5'h08;
  localparam logic [4:0] SAP_WL16 = 5'h10;
  localparam logic [4:0] SAP_K_MAX = 5'h1f;
  localparam logic [15:0] SAP_WORD_ZERO = 16'h0000;

  // bit clock ratio codes (multiples of the sample rate)
  localparam logic [1:0] SAP_BFS_16 = 2'h0;
  localparam logic [1:0] SAP_BFS_32 = 2'h1;
  localparam logic [1:0] SAP_BFS_48 = 2'h2;

  // bit clocks per channel slot
  localparam logic [4:0] SAP_SLOT_16FS = 5'h08;
  localparam logic [4:0] SAP_SLOT_32FS = 5'h10;
  localparam logic [4:0] SAP_SLOT_48FS = 5'h18;

  // master clock ticks per half bit clock, for 256fs and 384fs master clocks
  localparam logic [4:0] SAP_HALF_256_16 = 5'h08;
  localparam logic [4:0] SAP_HALF_256_32 = 5'h04;
  localparam logic [4:0] SAP_HALF_384_16 = 5'h0c;
  localparam logic [4:0] SAP_HALF_384_32 = 5'h06;
  localparam logic [4:0] SAP_HALF_384_48 = 5'h04;

  // channel index after reset: right
  localparam logic SAP_CHAN_RST = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       slave;
    logic [1:0] xfer;
    logic       lr_high_left;
    logic       msb_just;
    logic       bits16;
    logic       mclk384;
    logic [1:0] bfs;
  } sap_cfg_t;

  typedef struct packed {
    logic enable;
    logic psc_en;
    logic tx_idle;
    logic rx_idle;
    logic tx_dma;
    logic rx_dma;
  } sap_ctl_t;

  typedef enum logic [1:0] {CTL_OFF = 2'b01, CTL_ON = 2'b10} sap_ctl_st_t;
  typedef enum logic [2:0] {CH_IDLE = 3'b001, CH_RUN = 3'b010, CH_PAUSE = 3'b100} sap_ch_st_t;

endpackage

`default_nettype wire

// ===== logic/sap_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and registered flags.
  Assumes DEPTH is a power of two; flush empties it in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module sap_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          in_ready_nxt, out_valid_nxt, push, pop;

  always_comb
  begin
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wr_nxt = wr_r + AW'(push);
    rd_nxt = rd_r + AW'(pop);
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    if (flush)
    begin
      wr_nxt = '0;
      rd_nxt = '0;
      cnt_nxt = '0;
    end
    in_ready_nxt = cnt_nxt != (AW+1)'(DEPTH);
    out_valid_nxt = cnt_nxt != '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      in_ready <= in_ready_nxt;
      out_valid <= out_valid_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_r] <= in_data;
  end

  assign out_data = mem[rd_r];

endmodule

`default_nettype wire

// ===== logic/sap_prescaler.sv
/*
  Programmable divide-by-(N+1) prescaler giving a tick and a toggled level.
  Assumes div is held steady while en is high.
*/
`timescale 1ns/1ps
`default_nettype none

module sap_prescaler #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         reset,
  // control
  input  wire logic         en,
  input  wire logic [W-1:0] div,
  // outputs
  output logic              tick,
  output logic              level
);

  logic [W-1:0] cnt_r, cnt_nxt;
  logic         tick_nxt, level_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    level_nxt = level;
    if (!en)
    begin
      // bypassed: tick fires on every source clock, level is held low
      cnt_nxt = '0;
      tick_nxt = 1'b1;
      level_nxt = 1'b0;
    end
    else if (cnt_r == div)
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
      level_nxt = ~level;
    end
    else
      cnt_nxt = cnt_r + W'(1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
      level <= level_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== logic/sap_top.sv
/*
  Stereo audio serial port: FIFOs, prescalers, bit clock and channel
  sequencing, and the 16-bit sample shift registers towards a CODEC.
  Assumes control ports come from same-clock logic; link pins are async.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - two 5-bit prescalers, internal and codec clock
// - separate 64-byte transmit and receive FIFOs
// - master bit clock derived from master clock
// - channel machine plus separate FIFO control machine
// - 16-bit shift registers serialise and assemble words
// - transmit ready flag high when FIFO not empty
// - receive ready flag high when FIFO not full
// - link shifting continues during FIFO accesses
// - DMA requests follow the FIFO ready flags
// - transmit-only, receive-only and simultaneous modes
// - four-wire link; clock owner is master
// - two's complement samples sent MSB first
// - short transmit words padded with low zeros
// - receiver drops extra bits, zero-fills missing
// - standard format: MSB one bit after select
// - data sampled on bit clock rising edge
// - select marks channel; slave samples on rise
// - select change stores word, clears input register
// - 8/16-bit samples, standard and MSB-justified formats
// - MSB-justified: MSB right at select change; slave transmit sends it one bit later
// - prescalers divide by programmed value plus one
// - idle command holds channel select, pausing transfer
// - polarity picks which select level means left
module sap_top (
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         reset,
  // configuration and control
  input  wire sap_pkg::sap_cfg_t            cfg,
  input  wire sap_pkg::sap_ctl_t            ctl,
  input  wire logic [sap_pkg::SAP_PSC_W-1:0] psc_int_div,
  input  wire logic [sap_pkg::SAP_PSC_W-1:0] psc_codec_div,
  // transmit fifo write side
  input  wire logic                         tx_wr_valid,
  input  wire logic [sap_pkg::SAP_WORD_W-1:0] tx_wr_data,
  output logic                              tx_wr_ready,
  // receive fifo read side
  output logic                              rx_rd_valid,
  output logic [sap_pkg::SAP_WORD_W-1:0]    rx_rd_data,
  input  wire logic                         rx_rd_ready,
  // status
  output logic                              tx_fifo_ready,
  output logic                              rx_fifo_ready,
  output logic                              tx_dma_req,
  output logic                              rx_dma_req,
  output logic                              channel_index,
  // codec link
  output logic                              codec_master_clock,
  input  wire logic                         serial_bit_clock_i,
  output logic                              serial_bit_clock_o,
  output logic                              serial_bit_clock_oe,
  input  wire logic                         channel_select_line_i,
  output logic                              channel_select_line_o,
  output logic                              channel_select_line_oe,
  input  wire logic                         serial_data_in_line,
  output logic                              serial_data_out_line
);

  import sap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [4:0] wlen(input logic b16);
    return b16 ? SAP_WL16 : SAP_WL8;
  endfunction

  // places bit k (0 = MSB) of a word of the selected length
  function automatic logic [15:0] put_bit(input logic [15:0] w, input logic [4:0] k,
                                          input logic b, input logic b16);
    logic [15:0] r;
    r = w;
    if (k < wlen(b16))
      r[4'(wlen(b16) - 5'h01 - k)] = b;
    return r;
  endfunction

  function automatic logic get_bit(input logic [15:0] w, input logic [4:0] k, input logic b16);
    logic r;
    r = 1'b0;
    if (k < wlen(b16))
      r = w[4'(wlen(b16) - 5'h01 - k)];
    return r;
  endfunction

  function automatic logic [4:0] sat_inc(input logic [4:0] k);
    return (k == SAP_K_MAX) ? k : k + 5'h01;
  endfunction

  function automatic logic [4:0] half_limit(input logic m384, input logic [1:0] bfs);
    logic [4:0] r;
    case ({m384, bfs})
      {1'b0, SAP_BFS_16}: r = SAP_HALF_256_16;
      {1'b1, SAP_BFS_16}: r = SAP_HALF_384_16;
      {1'b1, SAP_BFS_32}: r = SAP_HALF_384_32;
      {1'b1, SAP_BFS_48}: r = SAP_HALF_384_48;
      default:            r = SAP_HALF_256_32;
    endcase
    return r;
  endfunction

  // 48fs is not reachable from 256fs, so that pairing falls back to 32fs
  function automatic logic [4:0] slot_limit(input logic m384, input logic [1:0] bfs);
    logic [4:0] r;
    if (bfs == SAP_BFS_16)
      r = SAP_SLOT_16FS;
    else if (bfs == SAP_BFS_32 || !m384)
      r = SAP_SLOT_32FS;
    else
      r = SAP_SLOT_48FS;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic bclk_s1_r, bclk_s2_r, bclk_s3_r, lr_s1_r, lr_s2_r, sdi_s1_r, sdi_s2_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      bclk_s1_r <= 1'b0;
      bclk_s2_r <= 1'b0;
      bclk_s3_r <= 1'b0;
      lr_s1_r <= 1'b0;
      lr_s2_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
    end
    else
    begin
      bclk_s1_r <= serial_bit_clock_i;
      bclk_s2_r <= bclk_s1_r;
      bclk_s3_r <= bclk_s2_r;
      lr_s1_r <= channel_select_line_i;
      lr_s2_r <= lr_s1_r;
      sdi_s1_r <= serial_data_in_line;
      sdi_s2_r <= sdi_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control machine (fifo access) and channel machine
  sap_ctl_st_t ctl_st_r, ctl_st_nxt;
  sap_ch_st_t  ch_st_r, ch_st_nxt;
  logic        on, run, tx_on, rx_on, tx_act, rx_act, pause;

  assign tx_on = cfg.xfer[1];
  assign rx_on = cfg.xfer[0];
  assign pause = (tx_on & ctl.tx_idle) | (rx_on & ctl.rx_idle);
  assign on = ctl_st_r == CTL_ON;
  assign run = ch_st_r == CH_RUN;
  assign tx_act = run & tx_on;
  assign rx_act = run & rx_on;

  always_comb
  begin
    case (ctl_st_r)
      CTL_OFF: ctl_st_nxt = ctl.enable ? CTL_ON : CTL_OFF;
      CTL_ON:  ctl_st_nxt = ctl.enable ? CTL_ON : CTL_OFF;
      default: ctl_st_nxt = CTL_OFF;
    endcase
    case (ch_st_r)
      CH_IDLE:  ch_st_nxt = on ? CH_RUN : CH_IDLE;
      CH_RUN:   ch_st_nxt = !on ? CH_IDLE : (pause ? CH_PAUSE : CH_RUN);
      CH_PAUSE: ch_st_nxt = !on ? CH_IDLE : (pause ? CH_PAUSE : CH_RUN);
      default:  ch_st_nxt = CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ctl_st_r <= CTL_OFF;
      ch_st_r <= CH_IDLE;
    end
    else
    begin
      ctl_st_r <= ctl_st_nxt;
      ch_st_r <= ch_st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers and fifos
  logic                  mclk_tick;
  logic                  txf_valid, txf_pop, rxf_ready;
  logic [SAP_WORD_W-1:0] txf_data;
  logic                  rx_push_r, rx_push_nxt;
  logic [15:0]           rx_word_r, rx_word_nxt;

  sap_prescaler #(.W(SAP_PSC_W)) u_psc_int (
    .clk_sys (clk_sys),
    .reset   (reset),
    .en      (ctl.psc_en),
    .div     (psc_int_div),
    .tick    (mclk_tick),
    .level   ()
  );

  sap_prescaler #(.W(SAP_PSC_W)) u_psc_codec (
    .clk_sys (clk_sys),
    .reset   (reset),
    .en      (ctl.psc_en),
    .div     (psc_codec_div),
    .tick    (),
    .level   (codec_master_clock)
  );

  // fifos are flushed while the port is off, so they restart empty
  sap_fifo #(.W(SAP_WORD_W), .DEPTH(SAP_FIFO_DEPTH)) u_tx_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .flush     (!on),
    .in_valid  (tx_wr_valid & on),
    .in_data   (tx_wr_data),
    .in_ready  (tx_wr_ready),
    .out_valid (txf_valid),
    .out_data  (txf_data),
    .out_ready (txf_pop)
  );

  // a full receive fifo drops the word; the link is never stalled
  sap_fifo #(.W(SAP_WORD_W), .DEPTH(SAP_FIFO_DEPTH)) u_rx_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .flush     (!on),
    .in_valid  (rx_push_r),
    .in_data   (rx_word_r),
    .in_ready  (rxf_ready),
    .out_valid (rx_rd_valid),
    .out_data  (rx_rd_data),
    .out_ready (rx_rd_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master bit clock generator and channel sequencer
  logic [4:0] half_r, half_nxt, bit_r, bit_nxt;
  logic       bclk_r, bclk_nxt, lr_r, lr_nxt, rise_m, fall_m;

  always_comb
  begin
    half_nxt = half_r;
    bclk_nxt = bclk_r;
    bit_nxt = bit_r;
    lr_nxt = lr_r;
    rise_m = 1'b0;
    fall_m = 1'b0;
    if (!on || cfg.slave)
    begin
      half_nxt = '0;
      bclk_nxt = 1'b0;
      bit_nxt = '0;
      lr_nxt = SAP_CHAN_RST;
    end
    else if (run && mclk_tick)
    begin
      if (half_r == half_limit(cfg.mclk384, cfg.bfs) - 5'h01)
      begin
        half_nxt = '0;
        bclk_nxt = ~bclk_r;
        rise_m = ~bclk_r;
        fall_m = bclk_r;
        if (bclk_r)
        begin
          // select changes on a falling edge at the end of each slot
          if (bit_r == slot_limit(cfg.mclk384, cfg.bfs) - 5'h01)
          begin
            bit_nxt = '0;
            lr_nxt = ~lr_r;
          end
          else
            bit_nxt = bit_r + 5'h01;
        end
      end
      else
        half_nxt = half_r + 5'h01;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      half_r <= '0;
      bclk_r <= 1'b0;
      bit_r <= '0;
      lr_r <= SAP_CHAN_RST;
    end
    else
    begin
      half_r <= half_nxt;
      bclk_r <= bclk_nxt;
      bit_r <= bit_nxt;
      lr_r <= lr_nxt;
    end
  end

  // common edge events; internal select is 0 for left, 1 for right
  logic rise_ev, fall_ev, lr_rx, lr_tx;
  logic rx_lr_r, rx_lr_nxt;

  assign rise_ev = cfg.slave ? (on & bclk_s2_r & ~bclk_s3_r) : rise_m;
  assign fall_ev = cfg.slave ? (on & ~bclk_s2_r & bclk_s3_r) : fall_m;
  assign lr_rx = cfg.slave ? (lr_s2_r ^ cfg.lr_high_left) : lr_r;
  assign lr_tx = cfg.slave ? rx_lr_r : lr_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // receive shift register
  logic [15:0] rx_sh_r, rx_sh_nxt;
  logic [4:0]  rx_k_r, rx_k_nxt;
  logic        rx_arm_r, rx_arm_nxt, rx_chg;

  always_comb
  begin
    rx_lr_nxt = rx_lr_r;
    rx_sh_nxt = rx_sh_r;
    rx_k_nxt = rx_k_r;
    rx_arm_nxt = rx_arm_r;
    rx_push_nxt = 1'b0;
    rx_word_nxt = rx_word_r;
    rx_chg = 1'b0;
    if (!on)
    begin
      rx_sh_nxt = '0;
      rx_k_nxt = '0;
      rx_arm_nxt = 1'b0;
    end
    else if (rise_ev)
    begin
      rx_lr_nxt = lr_rx;
      rx_chg = lr_rx != rx_lr_r;
      if (rx_chg && !cfg.msb_just)
      begin
        // standard format: the bit at the change is the old word's last
        rx_word_nxt = put_bit(rx_sh_r, rx_k_r, sdi_s2_r, cfg.bits16);
        rx_push_nxt = rx_arm_r & rx_act;
        rx_sh_nxt = '0;
        rx_k_nxt = '0;
        rx_arm_nxt = 1'b1;
      end
      else if (rx_chg)
      begin
        rx_word_nxt = rx_sh_r;
        rx_push_nxt = rx_arm_r & rx_act;
        rx_sh_nxt = put_bit(SAP_WORD_ZERO, 5'h00, sdi_s2_r, cfg.bits16);
        rx_k_nxt = 5'h01;
        rx_arm_nxt = 1'b1;
      end
      else
      begin
        // bits past the word length are ignored, missing ones stay zero
        rx_sh_nxt = put_bit(rx_sh_r, rx_k_r, sdi_s2_r, cfg.bits16);
        rx_k_nxt = sat_inc(rx_k_r);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_lr_r <= SAP_CHAN_RST;
      rx_sh_r <= '0;
      rx_k_r <= '0;
      rx_arm_r <= 1'b0;
      rx_push_r <= 1'b0;
      rx_word_r <= '0;
    end
    else
    begin
      rx_lr_r <= rx_lr_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_k_r <= rx_k_nxt;
      rx_arm_r <= rx_arm_nxt;
      rx_push_r <= rx_push_nxt;
      rx_word_r <= rx_word_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit shift register
  logic [15:0] tx_word_r, tx_word_nxt;
  logic [4:0]  tx_k_r, tx_k_nxt;
  logic        tx_lr_r, tx_lr_nxt, sdo_nxt, tx_chg;

  always_comb
  begin
    tx_lr_nxt = tx_lr_r;
    tx_k_nxt = tx_k_r;
    tx_word_nxt = tx_word_r;
    sdo_nxt = serial_data_out_line;
    txf_pop = 1'b0;
    tx_chg = 1'b0;
    if (!on)
    begin
      tx_lr_nxt = SAP_CHAN_RST;
      tx_k_nxt = '0;
      tx_word_nxt = '0;
      sdo_nxt = 1'b0;
    end
    else if (fall_ev)
    begin
      tx_chg = lr_tx != tx_lr_r;
      tx_lr_nxt = lr_tx;
      tx_k_nxt = tx_chg ? 5'h00 : sat_inc(tx_k_r);
      if (tx_chg)
      begin
        // an empty fifo or a paused direction sends silence
        txf_pop = tx_act & txf_valid;
        tx_word_nxt = txf_pop ? txf_data : SAP_WORD_ZERO;
      end
      // standard master format lags one bit behind the select change
      if (cfg.msb_just || cfg.slave)
        sdo_nxt = tx_act & get_bit(tx_word_nxt, tx_k_nxt, cfg.bits16);
      else
        sdo_nxt = tx_act & get_bit(tx_word_r, tx_k_r, cfg.bits16);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_lr_r <= SAP_CHAN_RST;
      tx_k_r <= '0;
      tx_word_r <= '0;
      serial_data_out_line <= 1'b0;
    end
    else
    begin
      tx_lr_r <= tx_lr_nxt;
      tx_k_r <= tx_k_nxt;
      tx_word_r <= tx_word_nxt;
      serial_data_out_line <= sdo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status and pin drivers
  logic tx_dma_nxt, rx_dma_nxt, chan_nxt, lr_pin_nxt, drv_nxt;

  always_comb
  begin
    tx_dma_nxt = on & ctl.tx_dma & txf_valid;
    rx_dma_nxt = on & ctl.rx_dma & rxf_ready;
    chan_nxt = rise_ev ? lr_rx : channel_index;
    lr_pin_nxt = lr_nxt ^ cfg.lr_high_left;
    drv_nxt = on & ~cfg.slave;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_fifo_ready <= 1'b0;
      rx_fifo_ready <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      channel_index <= SAP_CHAN_RST;
      channel_select_line_o <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
      channel_select_line_oe <= 1'b0;
    end
    else
    begin
      tx_fifo_ready <= txf_valid;
      rx_fifo_ready <= rxf_ready;
      tx_dma_req <= tx_dma_nxt;
      rx_dma_req <= rx_dma_nxt;
      channel_index <= chan_nxt;
      channel_select_line_o <= lr_pin_nxt;
      serial_bit_clock_oe <= drv_nxt;
      channel_select_line_oe <= drv_nxt;
    end
  end

  assign serial_bit_clock_o = bclk_r;

endmodule

`default_nettype wire

// ===== sim/sap_codec_model.sv
/* slave codec model on the far side of the link.
   assumes the port masters bit clock and select */
`timescale 1ns/1ps
`default_nettype none
module sap_codec_model #(
  parameter logic [15:0] W0 = 16'hc35a,
  parameter logic [15:0] W1 = 16'h6e91
) (
  // four-wire link
  input wire logic bclk, lrck, oe, sdo, mj,
  output logic sdi,
  // last word heard
  output logic [15:0] got,
  output int got_n
);
  logic [15:0] sh = 16'h0000, acc, w;
  logic d = 1'b0, lt, lr, ch;
  assign w = lrck ? W1 : W0;
  // a released line flips rather than keep the last bit
  assign sdi = oe ? d : ~d;
  initial got_n = 0;
  always @(posedge oe)
  begin
    #1;
    lt = lrck;
    lr = lrck;
    acc = 16'h0000;
  end
  // settle first: select moves on the same edge as the fall
  always @(negedge bclk)
  begin
    #1;
    ch = lrck != lt;
    lt = lrck;
    d = (ch && mj) ? w[15] : sh[15];
    sh = !ch ? sh << 1 : mj ? w << 1 : w;
  end
  always @(posedge bclk)
  begin
    if (lrck != lr)
    begin
      got = mj ? acc : {acc[14:0], sdo};
      got_n++;
      acc = mj ? {15'h0000, sdo} : 16'h0000;
    end
    else
      acc = {acc[14:0], sdo};
    lr = lrck;
  end
endmodule
`default_nettype wire

// ===== sim/sap_top_chk.sv
/* pin and flag checker for the audio port.
   assumes master mode with fixed dividers */
`timescale 1ns/1ps
`default_nettype none
module sap_top_chk import sap_pkg::*; (
  // clock and control
  input wire logic clk_sys, reset,
  input wire sap_pkg::sap_cfg_t cfg,
  input wire sap_pkg::sap_ctl_t ctl,
  input wire logic [sap_pkg::SAP_PSC_W-1:0] psc_int_div, psc_codec_div,
  // flags
  input wire logic rx_fifo_ready, tx_dma_req, rx_dma_req, channel_index,
  // link
  input wire logic codec_master_clock, serial_bit_clock_o, serial_bit_clock_oe,
  input wire logic channel_select_line_o, channel_select_line_oe, serial_data_out_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_rst_state: assert property ($past(reset) |-> channel_index && !serial_bit_clock_oe
    && !channel_select_line_oe && !tx_dma_req) else $error("bad reset state");
  // the port turns on one cycle after enable, so requests trail it by two
  a_tx_dma: assert property (tx_dma_req |-> $past(ctl.tx_dma) && $past(ctl.enable, 2))
    else $error("tx request unasked");
  a_rx_dma: assert property (rx_dma_req |-> $past(ctl.rx_dma) && $past(ctl.enable, 2))
    else $error("rx request unasked");
  a_chan_index: assert property ($rose(serial_bit_clock_o) && channel_select_line_oe
    |-> channel_index == (channel_select_line_o ^ cfg.lr_high_left)) else $error("channel index off select");
  a_cmclk_off: assert property ((!ctl.psc_en) [*2] |-> !codec_master_clock)
    else $error("codec clock runs");
  a_cmclk_div: assert property ($rose(codec_master_clock) && ctl.psc_en && psc_codec_div == 5'h01
    |=> codec_master_clock ##1 !codec_master_clock) else $error("codec clock period");
  a_bclk_half: assert property ($rose(serial_bit_clock_o) && cfg.bfs == SAP_BFS_32 && !cfg.mclk384
    && ctl.psc_en && psc_int_div == 5'h00 |=> serial_bit_clock_o [*3] ##1 !serial_bit_clock_o)
    else $error("bit clock half period");
  a_sel_fall: assert property ($changed(channel_select_line_o) && $past(channel_select_line_oe)
    && channel_select_line_oe |-> $fell(serial_bit_clock_o)) else $error("select off the fall");
  a_sdo_fall: assert property ($changed(serial_data_out_line) && $past(serial_bit_clock_oe)
    && serial_bit_clock_oe |-> $fell(serial_bit_clock_o)) else $error("data off the fall");
  c_sel: cover property ($fell(channel_select_line_o) && channel_select_line_oe);
  c_rx_full: cover property (!rx_fifo_ready && ctl.enable);
  c_tx_dma: cover property (tx_dma_req);
endmodule
bind sap_top sap_top_chk sap_top_chk_i (.*);
`default_nettype wire

// ===== sim/tb.sv
/* bench: port as master against the codec model.
   assumes design and model compiled first */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sap_pkg::*;
  localparam logic [15:0] W0 = 16'hc35a;
  localparam logic [15:0] W1 = 16'h6e91;
  logic clk_sys = 1'b0, reset = 1'b1, tx_wr_valid = 1'b0, rx_rd_ready = 1'b0;
  sap_cfg_t cfg = '0;
  sap_ctl_t ctl = '0;
  logic [SAP_PSC_W-1:0] psc_int_div = 5'h00, psc_codec_div = 5'h01;
  logic [15:0] tx_wr_data = 16'h0000, lf = 16'h0058, rx_rd_data, got, s;
  logic tx_wr_ready, rx_rd_valid, tx_fifo_ready, rx_fifo_ready, tx_dma_req, rx_dma_req, channel_index;
  logic codec_master_clock, serial_bit_clock_o, serial_bit_clock_oe, serial_bit_clock_i;
  logic channel_select_line_o, channel_select_line_oe, channel_select_line_i;
  logic serial_data_in_line, serial_data_out_line;
  int got_n, err_count = 0, total_checks = 0;
  logic [15:0] txq[$], rxq[$];
  assign serial_bit_clock_i = serial_bit_clock_oe & serial_bit_clock_o;
  assign channel_select_line_i = channel_select_line_oe & channel_select_line_o;
  always #2 clk_sys = ~clk_sys;
  sap_top sap_top_i (.*);
  sap_codec_model #(.W0(W0), .W1(W1)) sap_codec_model_i (.bclk(serial_bit_clock_i), .lrck(channel_select_line_i),
    .oe(serial_bit_clock_oe), .sdo(serial_data_out_line), .mj(cfg.msb_just), .sdi(serial_data_in_line),
    .got(got), .got_n(got_n));
  task automatic test_done;
    if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] v);
    total_checks++;
    if (v !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask
  task automatic lim(int k, int n);
    if (k >= n)
    begin
      err_count++;
      test_done;
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // received word i in link order, left first; 8-bit words keep the top byte
  function automatic logic [15:0] rxw(int i, logic p, logic b16);
    logic [15:0] w;
    w = ((i % 2) ^ p) ? W1 : W0;
    return b16 ? w : {8'h00, w[15:8]};
  endfunction
  task automatic wr(logic [15:0] w);
    int k;
    tx_wr_valid <= 1'b1;
    tx_wr_data <= w;
    for (k = 0; k < 500; k++)
    begin
      @(posedge clk_sys);
      if (tx_wr_ready === 1'b1) break;
    end
    lim(k, 500);
  endtask
  task automatic run(sap_cfg_t c, int nw);
    int k;
    reset <= 1'b1;
    rx_rd_ready <= 1'b0;
    cfg <= c;
    ctl <= '0;
    cyc(4);
    reset <= 1'b0;
    cyc(2);
    chk("reset", 16'h0010, {11'h000, channel_index, tx_fifo_ready, tx_dma_req, serial_bit_clock_oe, 1'b0});
    ctl <= sap_ctl_t'(6'h33);
    cyc(4);
    chk("select", {14'h0000, 1'b1, ~c.lr_high_left},
      {14'h0000, channel_select_line_oe, channel_select_line_o});
    txq = {16'h0000};
    rxq = {};
    for (k = 0; k < nw; k++) rxq.push_back(rxw(k, c.lr_high_left, c.bits16));
    for (k = 0; k < nw; k++)
    begin
      lf = nx(lf);
      wr(lf);
      txq.push_back(c.bits16 ? lf : {8'h00, lf[7:0]});
    end
    tx_wr_valid <= 1'b0;
    if (nw == 32)
    begin
      cyc(2);
      chk("tx full", 16'h0003, {13'h0000, tx_wr_ready, tx_fifo_ready, tx_dma_req});
      for (k = 0; k < 6000 && rx_fifo_ready !== 1'b0; k++) cyc(1);
      lim(k, 6000);
      chk("rx full", 16'h0000, {12'h000, rx_fifo_ready, rx_dma_req, tx_fifo_ready, tx_dma_req});
    end
    // reader stalls about half the time while the link keeps running
    for (k = 0; k < 30000 && rxq.size() + txq.size() > 0; k++)
    begin
      cyc(1);
      lf = nx(lf);
      rx_rd_ready <= lf[0];
    end
    lim(k, 30000);
  endtask
  always @(got_n) if (txq.size() > 0) chk("link word", txq.pop_front(), got);
  always @(posedge clk_sys)
    if (rx_rd_valid === 1'b1 && rx_rd_ready === 1'b1 && rxq.size() > 0)
      chk("rx", rxq.pop_front(), rx_rd_data);
  initial
  begin
    run(sap_cfg_t'(9'h0c9), 32);
    run(sap_cfg_t'(9'h0f4), 4);
    ctl <= sap_ctl_t'(6'h3b);
    cyc(8);
    s = {14'h0000, channel_select_line_o, serial_bit_clock_o};
    cyc(300);
    chk("idle", s, {14'h0000, channel_select_line_o, serial_bit_clock_o});
    test_done;
  end
endmodule
`default_nettype wire
